// ===== tsp_defines.svh
// Register offsets, field positions, reset values and widths of the transmitter configuration bank.
`ifndef TSP_DEFINES_SVH
`define TSP_DEFINES_SVH

`define TSP_ADDR_W          8
`define TSP_DATA_W          8

`define TSP_OFS_PA_CAP      8'h07
`define TSP_OFS_LOOP_CFG    8'h08
`define TSP_OFS_PUMP_CFG    8'h09
`define TSP_OFS_TXEN_MAIN   8'h0a
`define TSP_OFS_WORD_HIGH   8'h0b
`define TSP_OFS_WORD_MID    8'h0c
`define TSP_OFS_WORD_LOW    8'h0d
`define TSP_OFS_TXEN_ALIAS  8'h10

`define TSP_CAP_HI          4
`define TSP_CAP_LO          0
`define TSP_OFFSET_HI       7
`define TSP_OFFSET_LO       6
`define TSP_FRAC_BIT        5
`define TSP_LO_DIVIDER_SELECT_HI        2
`define TSP_LO_DIVIDER_SELECT_LO        1
`define TSP_LOSRC_BIT       0
`define TSP_PUMP_HI         1
`define TSP_PUMP_LO         0
`define TSP_TXEN_BIT        2

`define TSP_RST_CAP         5'h00
`define TSP_RST_OFFSET      2'h1
`define TSP_RST_FRAC        1'h1
`define TSP_RST_LO_DIVIDER_SELECT       2'h0
`define TSP_RST_LOSRC       1'h0
`define TSP_RST_PUMP        2'h0
`define TSP_RST_TXEN        1'h0
`define TSP_RST_WORD_HIGH   8'h13
`define TSP_RST_WORD_MID    8'hb0
`define TSP_RST_WORD_LOW    8'h00

`define TSP_BYTES_NONE      3'h0
`define TSP_BYTES_ALL       3'h7
`define TSP_BYTE_HIGH       2
`define TSP_BYTE_MID        1
`define TSP_BYTE_LOW        0

`endif

// ===== tsp_pkg.sv
// Types shared by the transmitter configuration bank.
`include "tsp_defines.svh"

package tsp_pkg;

    typedef logic [`TSP_ADDR_W-1:0] tsp_addr_t;
    typedef logic [`TSP_DATA_W-1:0] tsp_byte_t;
    typedef logic [23:0]            tsp_word_t;

    // Synthesizer loop and charge-pump controls as seen by the analog section.
    typedef struct packed {
        logic [1:0] pumpOffsetLevel;
        logic       fractionalSelect;
        logic [1:0] loDividerSelect;
        logic       loSourceSelect;
        logic [1:0] pumpCurrentSelect;
    } tsp_synth_cfg_s;

    // One register access from the serial front end.
    typedef struct packed {
        logic      wrStrobe;
        logic      rdStrobe;
        tsp_addr_t addr;
        tsp_byte_t wrData;
    } tsp_reg_req_s;

endpackage : tsp_pkg

// ===== tsp_config_regs.sv
// Configuration register bank for the PA, synthesizer and transmit enable.
`timescale 1ns/10ps
// Summary of operation
// R1 - Five-bit PA shunt capacitance, 175 fF steps
// R2 - Pump offset code 0..3: 0,5,10,15 percent
// R3 - Host clears pump offset for integer-N
// R4 - Bit 5 selects integer or fractional synthesis
// R5 - LO divider code: off, 4, 8, 12
// R6 - Bit 0 selects ring oscillator or LC
// R7 - Host picks LC low noise, ring low current
// R8 - Pump current code 0..3: 5..20 microamps
// R9 - Programmable mode sends data only when enabled
// R10 - Three bytes, high first, form tuning word
// R11 - Alias address shares the one transmit enable
// R12 - Host writes zero reserved, fields read back
// R13 - Tuning word applied after all three bytes
`include "tsp_defines.svh"

module tsp_config_regs (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire tsp_pkg::tsp_reg_req_s   regReq,
    input  wire logic                    programmableMode,
    input  wire logic                    txDataPin,
    output logic     [7:0]               regRdData,
    output logic                         regRdValid,
    output logic     [4:0]               paShuntCapacitance,
    output tsp_pkg::tsp_synth_cfg_s      synthCfg,
    output logic                         hostTxEnable,
    output tsp_pkg::tsp_word_t           synthTuningWord,
    output logic                         txDataOut
);
    import tsp_pkg::*;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [4:0]     cap_r,     cap_nxt;
    tsp_synth_cfg_s cfg_r,     cfg_nxt;
    logic           txEn_r,    txEn_nxt;
    tsp_byte_t      wHigh_r,   wHigh_nxt;
    tsp_byte_t      wMid_r,    wMid_nxt;
    tsp_byte_t      wLow_r,    wLow_nxt;
    logic [2:0]     seen_r,    seen_nxt;
    tsp_word_t      word_r,    word_nxt;
    tsp_byte_t      rd_r,      rd_nxt;
    logic           rdV_r,     rdV_nxt;
    logic           dSync1_r,  dSync2_r;
    logic           txOut_r,   txOut_nxt;
    logic           wr;

    assign wr = regReq.wrStrobe;

    always_comb begin
        cap_nxt  = cap_r;
        cfg_nxt  = cfg_r;
        txEn_nxt = txEn_r;
        wHigh_nxt = wHigh_r;
        wMid_nxt = wMid_r;
        wLow_nxt = wLow_r;
        seen_nxt = seen_r;
        word_nxt = word_r;
        if (wr) begin
            case (regReq.addr)
                `TSP_OFS_PA_CAP: begin
                    cap_nxt = regReq.wrData[`TSP_CAP_HI:`TSP_CAP_LO]; // [R1]
                end
                `TSP_OFS_LOOP_CFG: begin
                    cfg_nxt.pumpOffsetLevel = regReq.wrData[`TSP_OFFSET_HI:`TSP_OFFSET_LO]; // [R2]
                    cfg_nxt.fractionalSelect = regReq.wrData[`TSP_FRAC_BIT]; // [R4]
                    cfg_nxt.loDividerSelect = regReq.wrData[`TSP_LO_DIVIDER_SELECT_HI:`TSP_LO_DIVIDER_SELECT_LO]; // [R5]
                    cfg_nxt.loSourceSelect = regReq.wrData[`TSP_LOSRC_BIT]; // [R6]
                end
                `TSP_OFS_PUMP_CFG: begin
                    cfg_nxt.pumpCurrentSelect = regReq.wrData[`TSP_PUMP_HI:`TSP_PUMP_LO]; // [R8]
                end
                `TSP_OFS_TXEN_MAIN, `TSP_OFS_TXEN_ALIAS: begin
                    txEn_nxt = regReq.wrData[`TSP_TXEN_BIT]; // [R11]
                end
                `TSP_OFS_WORD_HIGH: begin
                    wHigh_nxt = regReq.wrData;
                    seen_nxt[`TSP_BYTE_HIGH] = 1'b1;
                end
                `TSP_OFS_WORD_MID: begin
                    wMid_nxt = regReq.wrData;
                    seen_nxt[`TSP_BYTE_MID] = 1'b1;
                end
                `TSP_OFS_WORD_LOW: begin
                    wLow_nxt = regReq.wrData;
                    seen_nxt[`TSP_BYTE_LOW] = 1'b1;
                end
                default: begin
                end
            endcase
        end
        // The word moves to the synthesizer only once every byte is fresh.
        if (seen_nxt == `TSP_BYTES_ALL) begin
            word_nxt = {wHigh_nxt, wMid_nxt, wLow_nxt}; // [R10] [R13]
            seen_nxt = `TSP_BYTES_NONE;
        end
    end

    // ------------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------------
    always_comb begin
        rdV_nxt = regReq.rdStrobe;
        rd_nxt  = rd_r;
        if (regReq.rdStrobe) begin
            case (regReq.addr)
                `TSP_OFS_PA_CAP:     rd_nxt = {3'h0, cap_r}; // [R12]
                `TSP_OFS_LOOP_CFG:   rd_nxt = {cfg_r.pumpOffsetLevel, cfg_r.fractionalSelect,
                                               2'h0, cfg_r.loDividerSelect,
                                               cfg_r.loSourceSelect};
                `TSP_OFS_PUMP_CFG:   rd_nxt = {6'h00, cfg_r.pumpCurrentSelect};
                `TSP_OFS_TXEN_MAIN,
                `TSP_OFS_TXEN_ALIAS: rd_nxt = {5'h00, txEn_r, 2'h0}; // [R11]
                `TSP_OFS_WORD_HIGH:  rd_nxt = wHigh_r;
                `TSP_OFS_WORD_MID:   rd_nxt = wMid_r;
                `TSP_OFS_WORD_LOW:   rd_nxt = wLow_r;
                default:             rd_nxt = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Transmit data gate
    // ------------------------------------------------------------------
    always_comb begin
        txOut_nxt = dSync2_r;
        if (programmableMode) begin
            txOut_nxt = dSync2_r & txEn_r; // [R9]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cap_r    <= `TSP_RST_CAP;
            cfg_r    <= {`TSP_RST_OFFSET, `TSP_RST_FRAC, `TSP_RST_LO_DIVIDER_SELECT, `TSP_RST_LOSRC,
                         `TSP_RST_PUMP};
            txEn_r   <= `TSP_RST_TXEN;
            wHigh_r  <= `TSP_RST_WORD_HIGH;
            wMid_r   <= `TSP_RST_WORD_MID;
            wLow_r   <= `TSP_RST_WORD_LOW;
            seen_r   <= `TSP_BYTES_NONE;
            word_r   <= {`TSP_RST_WORD_HIGH, `TSP_RST_WORD_MID, `TSP_RST_WORD_LOW};
            rd_r     <= 8'h00;
            rdV_r    <= 1'b0;
            dSync1_r <= 1'b0;
            dSync2_r <= 1'b0;
            txOut_r  <= 1'b0;
        end else begin
            cap_r    <= cap_nxt;
            cfg_r    <= cfg_nxt;
            txEn_r   <= txEn_nxt;
            wHigh_r  <= wHigh_nxt;
            wMid_r   <= wMid_nxt;
            wLow_r   <= wLow_nxt;
            seen_r   <= seen_nxt;
            word_r   <= word_nxt;
            rd_r     <= rd_nxt;
            rdV_r    <= rdV_nxt;
            dSync1_r <= txDataPin;
            dSync2_r <= dSync1_r;
            txOut_r  <= txOut_nxt;
        end
    end

    assign regRdData          = rd_r;
    assign regRdValid         = rdV_r;
    assign paShuntCapacitance = cap_r;
    assign synthCfg           = cfg_r;
    assign hostTxEnable       = txEn_r;
    assign synthTuningWord    = word_r;
    assign txDataOut          = txOut_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_wrAt(logic [7:0] a);
        regReq.wrStrobe && regReq.addr == a;
    endsequence

    property p_capWrite;
        @(posedge clk) disable iff (rst)
        s_wrAt(`TSP_OFS_PA_CAP) |=>
            paShuntCapacitance == $past(regReq.wrData[`TSP_CAP_HI:`TSP_CAP_LO]);
    endproperty
    a_capWrite: assert property (p_capWrite) else $error("PA cap not loaded."); // [R1]

    property p_offsetWrite;
        @(posedge clk) disable iff (rst)
        s_wrAt(`TSP_OFS_LOOP_CFG) |=>
            synthCfg.pumpOffsetLevel == $past(regReq.wrData[`TSP_OFFSET_HI:`TSP_OFFSET_LO]);
    endproperty
    a_offsetWrite: assert property (p_offsetWrite) else $error("Pump offset wrong."); // [R2]

    property p_fracWrite;
        @(posedge clk) disable iff (rst)
        s_wrAt(`TSP_OFS_LOOP_CFG) |=>
            synthCfg.fractionalSelect == $past(regReq.wrData[`TSP_FRAC_BIT]);
    endproperty
    a_fracWrite: assert property (p_fracWrite) else $error("Mode bit wrong."); // [R4]

    property p_divSrcWrite;
        @(posedge clk) disable iff (rst)
        s_wrAt(`TSP_OFS_LOOP_CFG) |=>
            {synthCfg.loDividerSelect, synthCfg.loSourceSelect} ==
                $past(regReq.wrData[`TSP_LO_DIVIDER_SELECT_HI:`TSP_LOSRC_BIT]);
    endproperty
    a_divSrcWrite: assert property (p_divSrcWrite) else $error("LO select wrong."); // [R5] [R6]

    property p_pumpWrite;
        @(posedge clk) disable iff (rst)
        s_wrAt(`TSP_OFS_PUMP_CFG) |=>
            synthCfg.pumpCurrentSelect == $past(regReq.wrData[`TSP_PUMP_HI:`TSP_PUMP_LO]);
    endproperty
    a_pumpWrite: assert property (p_pumpWrite) else $error("Pump current wrong."); // [R8]

    property p_txGate;
        @(posedge clk) disable iff (rst)
        (programmableMode && !hostTxEnable) |=> !txDataOut;
    endproperty
    a_txGate: assert property (p_txGate) else $error("Data sent while disabled."); // [R9]

    property p_aliasShared;
        @(posedge clk) disable iff (rst)
        s_wrAt(`TSP_OFS_TXEN_ALIAS) ##1 (regReq.rdStrobe && regReq.addr == `TSP_OFS_TXEN_MAIN)
            |=> regRdData[`TSP_TXEN_BIT] == hostTxEnable && regRdValid;
    endproperty
    a_aliasShared: assert property (p_aliasShared) else $error("Alias not shared."); // [R11]

    sequence s_threeBytes;
        s_wrAt(`TSP_OFS_WORD_HIGH) ##1 s_wrAt(`TSP_OFS_WORD_MID) ##1 s_wrAt(`TSP_OFS_WORD_LOW);
    endsequence

    property p_wordApplied;
        @(posedge clk) disable iff (rst)
        (seen_r == `TSP_BYTES_NONE) ##0 s_threeBytes |=>
            synthTuningWord == {$past(regReq.wrData, 3), $past(regReq.wrData, 2),
                                $past(regReq.wrData)};
    endproperty
    a_wordApplied: assert property (p_wordApplied) else $error("Word not applied."); // [R10]

    property p_wordHeld;
        @(posedge clk) disable iff (rst)
        (seen_nxt != `TSP_BYTES_NONE) |=> $stable(synthTuningWord);
    endproperty
    a_wordHeld: assert property (p_wordHeld) else $error("Partial word applied."); // [R13]

endmodule : tsp_config_regs

// ===== tsp_host_model.sv
// Host model that issues byte register requests to the configuration bank.
`timescale 1ns/10ps
module tsp_host_model (
    input  wire logic             clk,
    output tsp_pkg::tsp_reg_req_s regReq,
    input  wire logic [7:0]       regRdData,
    input  wire logic             regRdValid
);
    import tsp_pkg::*;
    initial regReq = '{1'b0, 1'b0, 8'h5a, 8'ha5};
    // A raw write skips the host's own reserved-bit and integer-mode care.
    function automatic logic [7:0] shape(input logic [7:0] a, input logic [7:0] d,
                                         input bit raw);
        logic [7:0] s;
        s = d;
        if (!raw) begin
            case (a)
                8'h07: s = d & 8'h1f;
                8'h08: s = d & 8'he7;
                8'h09: s = d & 8'h03;
                8'h0a, 8'h10: s = d & 8'h04;
                default: s = d;
            endcase
            if (a == 8'h08 && !s[5]) s[7:6] = 2'h0;
        end
        return s;
    endfunction : shape
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit raw,
                      output logic [7:0] s);
        s = shape(a, d, raw);
        @(negedge clk);
        regReq <= '{1'b1, 1'b0, a, s};
        @(negedge clk);
        regReq <= '{1'b0, 1'b0, ~a, ~s};
    endtask : wr
    // Three tuning bytes on consecutive cycles, high byte first.
    task automatic wr3(input logic [7:0] h, input logic [7:0] m, input logic [7:0] l);
        @(negedge clk);
        regReq <= '{1'b1, 1'b0, 8'h0b, h};
        @(negedge clk);
        regReq <= '{1'b1, 1'b0, 8'h0c, m};
        @(negedge clk);
        regReq <= '{1'b1, 1'b0, 8'h0d, l};
        @(negedge clk);
        regReq <= '{1'b0, 1'b0, 8'hf2, ~l};
    endtask : wr3
    // A write directly followed by a read in the next cycle.
    task automatic wrRd(input logic [7:0] wa, input logic [7:0] wd, input logic [7:0] ra,
                        output logic [7:0] s, output logic [7:0] d, output bit ok);
        s = shape(wa, wd, 1'b0);
        ok = 0;
        d = 8'h00;
        @(negedge clk);
        regReq <= '{1'b1, 1'b0, wa, s};
        @(negedge clk);
        regReq <= '{1'b0, 1'b1, ra, ~s};
        @(negedge clk);
        regReq <= '{1'b0, 1'b0, ~ra, s};
        if (regRdValid === 1'b1) begin
            ok = 1;
            d = regRdData;
        end
    endtask : wrRd
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
        ok = 0;
        d = 8'h00;
        @(negedge clk);
        regReq <= '{1'b0, 1'b1, a, ~a};
        for (int n = 0; n < 4 && !ok; n++) begin
            @(negedge clk);
            if (n == 0) regReq <= '{1'b0, 1'b0, ~a, a};
            if (regRdValid === 1'b1) begin
                ok = 1;
                d = regRdData;
            end
        end
    endtask : rd
endmodule : tsp_host_model

// ===== tsp_config_regs_tb.sv
// Self-checking testbench of the transmitter configuration bank.
`timescale 1ns/10ps
module tsp_config_regs_tb;
    import tsp_pkg::*;
    logic           clk = 1'b0;
    logic           rst = 1'b1;
    logic           progMode = 1'b0;
    logic           pin = 1'b0;
    tsp_reg_req_s   regReq;
    logic [7:0]     regRdData;
    logic           regRdValid;
    logic [4:0]     capOut;
    tsp_synth_cfg_s synthCfg;
    logic           txEn;
    tsp_word_t      wordOut;
    logic           txOut;
    int             errors = 0;
    int             checks = 0;
    int             mem [256];
    int             staged = 0;
    int             word = 'h13b000;
    logic [7:0]     tbl [10] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h10,
                                 8'h0e, 8'hff};
    always #5 clk = ~clk;
    tsp_host_model i_tsp_host_model (.clk(clk), .regReq(regReq), .regRdData(regRdData),
                                     .regRdValid(regRdValid));
    tsp_config_regs i_tsp_config_regs (.clk(clk), .rst(rst), .regReq(regReq),
        .programmableMode(progMode), .txDataPin(pin), .regRdData(regRdData),
        .regRdValid(regRdValid), .paShuntCapacitance(capOut), .synthCfg(synthCfg),
        .hostTxEnable(txEn), .synthTuningWord(wordOut), .txDataOut(txOut));
    // ------------------------------------------------------------------
    // Reference model and checks
    // ------------------------------------------------------------------
    task automatic stop_test;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    function automatic int idx(input logic [7:0] a);
        return (a == 8'h10) ? 'h0a : int'(a);
    endfunction : idx
    function automatic int keep(input logic [7:0] a);
        case (a)
            8'h07: return 'h1f;
            8'h08: return 'he7;
            8'h09: return 'h03;
            8'h0a, 8'h10: return 'h04;
            8'h0b, 8'h0c, 8'h0d: return 'hff;
            default: return 0;
        endcase
    endfunction : keep
    task automatic chkAll;
        chk(mem[7] & 'h1f, capOut);
        chk({mem[8][7:5], mem[8][2:0], mem[9][1:0]}, synthCfg);
        chk(mem['h0a][2], txEn);
        chk(word, wordOut);
    endtask : chkAll
    function automatic void note(input logic [7:0] a, input logic [7:0] s);
        if (keep(a) != 0) mem[idx(a)] = s & keep(a);
        if (a >= 8'h0b && a <= 8'h0d) staged |= 1 << ('h0d - a);
        if (staged == 7) begin
            word = (mem['h0b] << 16) | (mem['h0c] << 8) | mem['h0d];
            staged = 0;
        end
    endfunction : note
    task automatic doWr(input logic [7:0] a, input logic [7:0] d, input bit raw);
        logic [7:0] s;
        i_tsp_host_model.wr(a, d, raw, s);
        note(a, s);
        @(negedge clk);
        chkAll;
    endtask : doWr
    task automatic doRd(input logic [7:0] a);
        logic [7:0] d;
        bit         ok;
        i_tsp_host_model.rd(a, d, ok);
        if (!ok) begin
            errors++;
            stop_test;
        end
        chk(keep(a) != 0 ? mem[idx(a)] : 0, d);
    endtask : doRd
    task automatic doWrRd(input logic [7:0] wa, input logic [7:0] wd, input logic [7:0] ra);
        logic [7:0] s;
        logic [7:0] d;
        bit         ok;
        i_tsp_host_model.wrRd(wa, wd, ra, s, d, ok);
        note(wa, s);
        if (!ok) begin
            errors++;
            stop_test;
        end
        chk(keep(ra) != 0 ? mem[idx(ra)] : 0, d);
    endtask : doWrRd
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        mem = '{default: 0};
        mem[8] = 'h60;
        mem['h0b] = 'h13;
        mem['h0c] = 'hb0;
        void'($urandom(14954));
        repeat (4) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chkAll;
        foreach (tbl[i]) doRd(tbl[i]);
        doWr(8'h07, 8'h1b, 0);
        for (int i = 0; i < 4; i++) begin
            doWr(8'h08, {i[1:0], 1'b1, 2'b00, i[1:0], i[0]}, 0);
            doWr(8'h09, {6'h00, i[1:0]}, 0);
        end
        doWr(8'h08, 8'hc7, 0);
        doWr(8'h0b, 8'h21, 0);
        doWr(8'h0c, 8'h43, 0);
        doWr(8'h0b, 8'h65, 0);
        doWr(8'h0d, 8'h87, 0);
        i_tsp_host_model.wr3(8'h9a, 8'hbc, 8'hde);
        note(8'h0b, 8'h9a);
        note(8'h0c, 8'hbc);
        note(8'h0d, 8'hde);
        @(negedge clk);
        chkAll;
        for (int i = 0; i < 60; i++) begin
            doWr(tbl[$urandom % 10], 8'($urandom), 1'($urandom));
            doRd(tbl[$urandom % 10]);
        end
        for (int i = 0; i < 8; i++) begin
            doWr($urandom % 2 ? 8'h10 : 8'h0a, {5'h00, i[1], 2'h0}, 0);
            progMode = i[2];
            pin = i[0];
            repeat (4) @(negedge clk);
            chk(i[0] & (i[1] | ~i[2]), txOut);
            doRd(8'h0a);
            doRd(8'h10);
            doWrRd(8'h10, {5'h00, ~i[1], 2'h0}, 8'h0a);
        end
        stop_test;
    end
endmodule : tsp_config_regs_tb
